// *** hw/swip_port.sv ***
// Serial word input port: peripheral end of a gated 16-bit serial link.
// Assumes the link pins are asynchronous to ref_clk and that the APB
// master runs on ref_clk.
// Read data comes from a flop loaded in the APB setup cycle, so the
// status that software sees is the one of that cycle.
//
// Decided for this implementation: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps

module swip_port (
  // Clock and reset.
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Serial link pins, active low gate and clock.
  input  wire logic        readGateN,
  input  wire logic        shiftClkN,
  output logic             serialData
);

  localparam int BW = swip_pkg::WORD_BITS;

  // Elaboration check: the bit counter and read path fit 2 to 31 bits.
  if (BW < 2 || BW > 31) begin : g_width_check
    $error("swip_port: word width outside 2 to 31 bits");
  end

  // True when the bus address selects the register at this offset.
  function automatic logic hitOffset(input logic [7:0] addr,
                                     input logic [7:0] offset);
    return addr == offset;
  endfunction

  // Places the status flags at their field positions in a bus word.
  function automatic logic [31:0] statusWord(input logic busy,
                                             input logic done,
                                             input logic abort);
    logic [31:0] word;
    word = 32'h0000_0000;
    word[swip_pkg::STAT_BUSY_BIT]  = busy;
    word[swip_pkg::STAT_DONE_BIT]  = done;
    word[swip_pkg::STAT_ABORT_BIT] = abort;
    return word;
  endfunction

  // Synchroniser stages and delayed copies for edge detection.
  logic [1:0] gateSync_q;
  logic [1:0] clkSync_q;
  logic       gatePrev_q;
  logic       clkPrev_q;
  swip_pkg::swip_link_t link;

  // Registers and shifting state.
  logic [BW-1:0]          txWord_q;
  logic [1:0]             control_q;
  logic [BW-1:0]          shift_q;
  logic [4:0]             bitCnt_q;
  logic                   serial_q;
  logic                   done_q;
  logic                   abort_q;
  logic [15:0]            sent_q;
  logic [31:0]            rdData_q;
  swip_pkg::swip_state_t  state_q;
  swip_pkg::swip_apb_req_t req;

  // Decoded events and bus strobes.
  wire gateFall  = gatePrev_q & ~link.gateN;
  wire gateRise  = ~gatePrev_q & link.gateN;
  wire clkFall   = clkPrev_q & ~link.clkN & ~link.gateN;
  wire enabled   = control_q[swip_pkg::CTRL_EN_BIT];
  wire inShift   = state_q == swip_pkg::SWIP_SHIFT;
  wire lastBit   = bitCnt_q == 5'(BW - 1);
  wire wrAccess  = req.sel & req.enable & req.write;
  wire rdAccess  = req.sel & req.enable & ~req.write;
  wire hitTx     = hitOffset(req.addr, swip_pkg::TX_WORD_OFS);
  wire hitStat   = hitOffset(req.addr, swip_pkg::STATUS_OFS);
  wire hitCtrl   = hitOffset(req.addr, swip_pkg::CONTROL_OFS);
  wire hitSent   = hitOffset(req.addr, swip_pkg::SENT_OFS);
  wire hitAny    = hitTx | hitStat | hitCtrl | hitSent;
  wire rdStatus  = rdAccess & hitStat;

  assign link.gateN = gateSync_q[1];
  assign link.clkN  = clkSync_q[1];
  assign req.sel    = psel;
  assign req.enable = penable;
  assign req.write  = pwrite;
  assign req.addr   = paddr;
  assign req.wdata  = pwdata;

  // Zero wait-state APB; unmapped addresses answer with an error.
  assign pready  = 1'b1;
  assign pslverr = req.sel & req.enable & ~hitAny;

  // Read data is picked in the setup cycle and held in a flop for the
  // access phase, so the bus sees a registered value with no wait state.
  wire [31:0] rdMux    = hitTx   ? 32'(txWord_q) :
                         hitStat ? statusWord(inShift, done_q, abort_q) :
                         hitCtrl ? 32'(control_q) :
                         hitSent ? 32'(sent_q) : 32'h0000_0000;
  wire        rdSetup  = req.sel & ~req.enable & ~req.write;
  wire [31:0] rdData_d = rdSetup ? rdMux : 32'h0000_0000;

  // The flop is zero outside a read access, so stale data never shows.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rdData_q <= 32'h0000_0000;
    end else begin
      rdData_q <= rdData_d;
    end
  end

  assign prdata = rdData_q;

  // Two-flop synchronisers; only the second stage feeds the logic, so a
  // metastable first stage never reaches the edge detectors.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      gateSync_q <= 2'h3;
      clkSync_q  <= 2'h3;
      gatePrev_q <= 1'b1;
      clkPrev_q  <= 1'b1;
    end else begin
      gateSync_q <= {gateSync_q[0], readGateN};
      clkSync_q  <= {clkSync_q[0], shiftClkN};
      gatePrev_q <= link.gateN;
      clkPrev_q  <= link.clkN;
    end
  end

  // Software registers; a hardware set of a flag wins over its clear.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      txWord_q  <= swip_pkg::TX_WORD_RST;
      control_q <= swip_pkg::CONTROL_RST;
    end else if (wrAccess) begin
      if (hitTx) txWord_q <= req.wdata[BW-1:0];
      if (hitCtrl) control_q <= req.wdata[1:0];
    end
  end

  // Transfer engine: edge driven, so any bit period works whose levels each outlast the ref_clk synchroniser delay.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_q  <= swip_pkg::SWIP_IDLE;
      shift_q  <= '0;
      bitCnt_q <= '0;
      serial_q <= 1'b0;
      done_q   <= 1'b0;
      abort_q  <= 1'b0;
      sent_q   <= '0;
    end else begin
      // Only flags that the read returned are cleared, so a flag set
      // between setup and access is kept; a set in the same cycle wins.
      if (rdStatus) begin
        if (rdData_q[swip_pkg::STAT_DONE_BIT])  done_q  <= 1'b0;
        if (rdData_q[swip_pkg::STAT_ABORT_BIT]) abort_q <= 1'b0;
      end
      unique case (state_q)
        swip_pkg::SWIP_IDLE: begin
          serial_q <= control_q[swip_pkg::CTRL_IDLE_BIT];
          if (gateFall && enabled) begin
            shift_q  <= txWord_q;
            serial_q <= txWord_q[BW-1];
            bitCnt_q <= '0;
            state_q  <= swip_pkg::SWIP_SHIFT;
          end
        end
        swip_pkg::SWIP_SHIFT: begin
          if (gateRise) begin
            // Any rise in this state is early: the last fall leaves it.
            state_q <= swip_pkg::SWIP_IDLE;
            abort_q <= 1'b1;
          end else if (clkFall) begin
            if (lastBit) begin
              // Word complete; line is free now, park it.
              serial_q <= control_q[swip_pkg::CTRL_IDLE_BIT];
              done_q   <= 1'b1;
              sent_q   <= sent_q + 16'h0001;
              state_q  <= swip_pkg::SWIP_IDLE;
            end else begin
              shift_q  <= {shift_q[BW-2:0], 1'b0};
              serial_q <= shift_q[BW-2];
              bitCnt_q <= bitCnt_q + 5'h01;
            end
          end
        end
      endcase
    end
  end

  // Data is held from a flop between falling edges.
  assign serialData = serial_q;

endmodule // swip_port

// *** hw/swip_pkg.sv ***
// Package for the serial word input port: constants and carrier types.
// Assumes a 250 MHz system clock and an APB master on the same clock.
package swip_pkg;

  // Register byte offsets.
  localparam logic [7:0] TX_WORD_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS  = 8'h04;
  localparam logic [7:0] CONTROL_OFS = 8'h08;
  localparam logic [7:0] SENT_OFS    = 8'h0C;

  // Field positions.
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_ABORT_BIT = 2;
  localparam int CTRL_IDLE_BIT = 0;
  localparam int CTRL_EN_BIT   = 1;

  // Reset values.
  localparam logic [15:0] TX_WORD_RST = 16'h0000;
  localparam logic [1:0]  CONTROL_RST = 2'h2;

  // Bits per word.
  localparam int WORD_BITS = 16;

  // Link pins as seen by the block, already synchronised.
  typedef struct packed {
    logic gateN;
    logic clkN;
  } swip_link_t;

  // APB request fields.
  typedef struct packed {
    logic        sel;
    logic        enable;
    logic        write;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } swip_apb_req_t;

  // Transfer state.
  typedef enum logic [1:0] {
    SWIP_IDLE  = 2'b01,
    SWIP_SHIFT = 2'b10
  } swip_state_t;

endpackage

// *** verif/swip_sva.sv ***
// Checker for the serial word input port: bus answers and return line.
// Assumes it is bound to swip_port and that link pins move slowly.
`timescale 1ns/1ps
module swip_sva (
  // Clock, reset and bus.
  input wire logic        ref_clk,
  input wire logic        resetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Link pins.
  input wire logic        readGateN,
  input wire logic        shiftClkN,
  input wire logic        serialData
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // Access phase and idle-level write decode.
  wire acc     = psel && penable;
  wire ctlWr   = acc && pwrite && paddr == swip_pkg::CONTROL_OFS && readGateN;
  wire idleBit = pwdata[0];
  a_ready_high: assert property (pready) else $error("pready low");
  a_err_unmapped: assert property (acc && paddr[7:4] != 4'h0 |-> pslverr)
    else $error("unmapped without error");
  a_err_mapped: assert property (acc && paddr inside {8'h00, 8'h04, 8'h08,
    8'h0C} |-> !pslverr) else $error("mapped with error");
  a_err_quiet: assert property (!acc |-> !pslverr) else $error("stray error");
  a_rd_zero: assert property (!(acc && !pwrite) |-> prdata == 32'h0)
    else $error("read data outside read");
  a_idle_stable: assert property (
    (readGateN && !psel) [*6] |-> $stable(serialData)) else $error("idle moved");
  a_line_stable: assert property (
    (!readGateN && $stable(shiftClkN)) [*6] |-> $stable(serialData))
    else $error("line moved between clock falls");
  a_idle_write: assert property (
    ctlWr ##1 readGateN [*4] |-> serialData == $past(idleBit, 4))
    else $error("idle level not applied");
  c_start: cover property ($fell(readGateN));
  c_error: cover property (acc && pslverr);
  c_idle:  cover property (ctlWr);
endmodule  // swip_sva

// *** verif/swip_ctrl_model.sv ***
// Controlling unit model: drives gate and shift clock, samples the line.
// Assumes the testbench calls one task at a time; bit period is 160 ns.
`timescale 1ns/1ps
module swip_ctrl_model (
  // Return line.
  input wire logic serialData,
  // Gate and shift clock, both active low.
  output logic     readGateN,
  output logic     shiftClkN
);
  // A 160 ns bench bit period stands in for the slow field rates.
  localparam int HalfBit = 80;
  localparam int GapMin  = 34 * HalfBit;
  // Both lines rest high between transfers.
  initial begin
    readGateN = 1'b1;
    shiftClkN = 1'b1;
  end
  // One transfer of n pulses; the line is read only inside it.
  task automatic xfer(input int n, input int ext, output logic [15:0] w);
    realtime t0;
    w = 16'h0000;
    #1.3 readGateN = 1'b0;
    t0 = $realtime;
    for (int i = 0; i < n; i++) begin
      #HalfBit shiftClkN = 1'b0;
      w = {w[14:0], serialData};
      #HalfBit shiftClkN = 1'b1;
      if (i == 7) #(ext * 2 * HalfBit);
    end
    #HalfBit readGateN = 1'b1;
    #(2 * HalfBit);
    // Short frames still keep gate falls seventeen bit periods apart.
    if ($realtime - t0 < GapMin) #(GapMin - ($realtime - t0));
  endtask
  // Shared clock activity with the gate high.
  task automatic noise(input int n);
    repeat (n) begin
      #HalfBit shiftClkN = 1'b0;
      #HalfBit shiftClkN = 1'b1;
    end
  endtask
endmodule  // swip_ctrl_model

// *** verif/swip_port_tb.sv ***
// Testbench for swip_port: APB master, controller model and checks.
// Assumes the checker and the controller model are compiled first.
`timescale 1ns/1ps
module swip_port_tb;
  logic        ref_clk, resetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        readGateN, shiftClkN, serialData, se;
  logic [15:0] w, got;
  int          err_count, comparisons;
  swip_port swip_port_i (.ref_clk(ref_clk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .readGateN(readGateN), .shiftClkN(shiftClkN), .serialData(serialData));
  swip_ctrl_model swip_ctrl_model_i (.serialData(serialData),
    .readGateN(readGateN), .shiftClkN(shiftClkN));
  // Bus clock at 250 MHz.
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  task automatic chk(input string n, input logic [31:0] s, e);
    comparisons++;
    if (s !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  // One APB transfer; data and error are taken at the pready edge.
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge ref_clk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    se = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic conclude();
    if (err_count == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Main sequence: reset values, words, abort, idle level.
  initial begin
    {psel, penable, pwrite, paddr, pwdata, resetn} = '0;
    void'($urandom(32'h09FA));
    repeat (16) @(posedge ref_clk);
    resetn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0);
      chk("reset value", rd, i == 2 ? 32'h2 : 32'h0);
    end
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped error", se, 1'b1);
    for (int i = 1; i <= 4; i++) begin
      w = i == 1 ? 16'h8001 : 16'($urandom);
      apb(1'b1, swip_pkg::TX_WORD_OFS, {16'h0, w});
      fork
        swip_ctrl_model_i.xfer(16, i == 4 ? 8 : $urandom % 8, got);
        begin
          #600 apb(1'b1, swip_pkg::TX_WORD_OFS, {16'h0, ~w});
          apb(1'b0, swip_pkg::STATUS_OFS, 32'h0);
          chk("status busy", rd, 32'h1);
        end
      join
      chk("word", got, w);
      apb(1'b0, swip_pkg::STATUS_OFS, 32'h0);
      chk("status done", rd, 32'h2);
      apb(1'b0, swip_pkg::SENT_OFS, 32'h0);
      chk("sent count", rd, i);
    end
    apb(1'b0, swip_pkg::TX_WORD_OFS, 32'h0);
    chk("word readback", rd, {16'h0, ~w});
    // Frames cut short after five and after fifteen falls.
    for (int n = 5; n < 16; n += 10) begin
      swip_ctrl_model_i.xfer(n, 0, got);
      apb(1'b0, swip_pkg::STATUS_OFS, 32'h0);
      chk("status abort", rd, 32'h4);
    end
    apb(1'b1, swip_pkg::CONTROL_OFS, 32'h3);
    swip_ctrl_model_i.noise(8);
    @(negedge ref_clk);
    chk("idle level", serialData, 1'b1);
    // Disabled port: the line keeps its idle level and nothing counts.
    apb(1'b1, swip_pkg::CONTROL_OFS, 32'h1);
    swip_ctrl_model_i.xfer(16, 0, got);
    chk("disabled line", got, 16'hFFFF);
    apb(1'b0, swip_pkg::SENT_OFS, 32'h0);
    chk("sent when disabled", rd, 32'h4);
    conclude();
  end
  // Watchdog against a hung handshake or transfer.
  initial begin
    #200000;
    err_count++;
    conclude();
  end
endmodule  // swip_port_tb
bind swip_port swip_sva swip_sva_i (.ref_clk(ref_clk), .resetn(resetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .readGateN(readGateN), .shiftClkN(shiftClkN), .serialData(serialData));
